/* File: src/pfb_cfg.svh */
// constants for the position fix batch buffer: offsets, fields, limits
`ifndef PFB_CFG_SVH
`define PFB_CFG_SVH

// register byte offsets
`define PFB_A_CFG      8'h00
`define PFB_A_NOTIFY   8'h04
`define PFB_A_STATUS   8'h08
`define PFB_A_ISTAT    8'h0c
`define PFB_A_IMASK    8'h10

// config register fields
`define PFB_B_EN       0
`define PFB_B_NAV      1
`define PFB_B_DIST     2
`define PFB_B_PIN      3
`define PFB_DEPTH_LSB  16
`define PFB_DEPTH_MSB  25

// largest depth for each option pair {nav, dist}
`define PFB_MAX_00     10'd600
`define PFB_MAX_01     10'd443
`define PFB_MAX_10     10'd309
`define PFB_MAX_11     10'd261

// interrupt status bits
`define PFB_I_FILL     0
`define PFB_I_DROP     1
`define PFB_I_REJ      2
`define PFB_I_DONE     3

// bus answers and misc
`define PFB_RESP_OK    2'b00
`define PFB_RESP_ERR   2'b10
`define PFB_DROP_MAX   16'hffff

`endif

/* File: src/pfb_pkg.sv */
// types shared by the position fix batch buffer
`default_nettype none
package pfb_pkg;
    // retrieval sequencer states
    typedef enum logic [2:0] {
        PFB_IDLE,
        PFB_STAT,
        PFB_BASIC,
        PFB_NAV,
        PFB_DIST
    } pfb_state_t;
endpackage
`default_nettype wire

/* File: src/pfb_ring.sv */
// entry store for the batch buffer: one write port, one async read port
`timescale 1ns/1ns
`default_nettype none
module pfb_ring #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 600,
    parameter int AW    = 10
) (
    input  wire logic             aclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    // storage array, no reset needed
    logic [WIDTH-1:0] mem [DEPTH];

    // write on the clock
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read is combinational: old data seen during a same-slot write
    assign rdata = mem[raddr];
endmodule
`default_nettype wire

/* File: src/pfb_top.sv */
// position fix batch buffer with axi4-lite registers and entry stream
`timescale 1ns/1ns
`default_nettype none
`include "pfb_cfg.svh"
module pfb_top
    import pfb_pkg::*;
#(
    parameter int MAX_DEPTH = 600,
    parameter int CW        = 10
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        fix_valid,
    input  wire logic [31:0] fix_basic,
    input  wire logic [31:0] fix_nav,
    input  wire logic [31:0] fix_dist,
    input  wire logic        req_valid,
    input  wire logic        req_status_first,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [31:0]      out_data,
    output logic             out_status,
    output logic             out_last,
    output logic             fill_flag_pin,
    output logic             irq
);
    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // configuration state
    logic          cfg_en_q, cfg_nav_q, cfg_dist_q, cfg_pin_q;
    logic [CW-1:0] cfg_depth_q;          // entries
    logic [CW-1:0] notify_q;             // flag threshold
    logic [3:0]    istat_q, imask_q;     // interrupt status / mask
    // buffer state
    logic [CW-1:0] wr_ptr_q, rd_ptr_q, cnt_q, rem_q, rem_d;
    logic [15:0]   drop_cnt_q;           // overrun drops, saturating
    logic [31:0]   hold_nav_q, hold_dist_q;
    pfb_state_t    st_q, st_d;
    // bus state
    logic          aw_hold_q, w_hold_q;
    logic [7:0]    awaddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;
    // combinational helpers
    logic          active, full, store, drop, pop, flush, ofree;
    logic          load, ld_last, ld_stat, flag_d, done_ev;
    logic [31:0]   ld_data, cfg_rd, cfg_new, rd_word, stat_word;
    logic [CW-1:0] max_new, new_depth;
    logic          cfg_wr, cfg_bad, cfg_apply, rd_ok, wr_ok, do_wr;
    logic [95:0]   mem_rd;

    // current config as a register word
    always_comb begin
        cfg_rd = '0;
        cfg_rd[`PFB_B_EN]   = cfg_en_q;
        cfg_rd[`PFB_B_NAV]  = cfg_nav_q;
        cfg_rd[`PFB_B_DIST] = cfg_dist_q;
        cfg_rd[`PFB_B_PIN]  = cfg_pin_q;
        cfg_rd[`PFB_DEPTH_MSB:`PFB_DEPTH_LSB] = cfg_depth_q;
    end

    // status word: drops high, fill level low
    assign stat_word = {drop_cnt_q, {(16-CW){1'b0}}, cnt_q};

    // ---------------- axi4-lite write side ----------------
    assign do_wr     = aw_hold_q && w_hold_q && !bvalid;
    assign cfg_wr    = do_wr && awaddr_q == `PFB_A_CFG;
    assign cfg_new   = merge(cfg_rd, wdata_q, wstrb_q);
    assign new_depth = cfg_new[`PFB_DEPTH_MSB:`PFB_DEPTH_LSB];

    // largest allowed depth for the requested options
    always_comb begin
        unique case ({cfg_new[`PFB_B_NAV], cfg_new[`PFB_B_DIST]})
            2'b00:   max_new = `PFB_MAX_00;
            2'b01:   max_new = `PFB_MAX_01;
            2'b10:   max_new = `PFB_MAX_10;
            default: max_new = `PFB_MAX_11;
        endcase
    end
    assign cfg_bad   = new_depth > max_new;
    assign cfg_apply = cfg_wr && !cfg_bad;

    // known write targets
    always_comb begin
        unique case (awaddr_q)
            `PFB_A_CFG, `PFB_A_NOTIFY, `PFB_A_STATUS,
            `PFB_A_ISTAT, `PFB_A_IMASK: wr_ok = 1'b1;
            default:                    wr_ok = 1'b0;
        endcase
    end

    // address and data latches, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= awaddr;
            end else if (do_wr) begin
                aw_hold_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end else if (do_wr) begin
                w_hold_q <= 1'b0;
            end
            // ready only while the holding slot is free
            awready <= !(awvalid && awready) && (!aw_hold_q || do_wr);
            wready  <= !(wvalid && wready) && (!w_hold_q || do_wr);
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `PFB_RESP_OK;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= (wr_ok && !cfg_bad) ? `PFB_RESP_OK : `PFB_RESP_ERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // config, threshold and mask registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_en_q    <= 1'b0;
            cfg_nav_q   <= 1'b0;
            cfg_dist_q  <= 1'b0;
            cfg_pin_q   <= 1'b0;
            cfg_depth_q <= '0;
            notify_q    <= '0;
            imask_q     <= '0;
        end else begin
            if (cfg_apply) begin
                cfg_en_q    <= cfg_new[`PFB_B_EN];
                cfg_nav_q   <= cfg_new[`PFB_B_NAV];
                cfg_dist_q  <= cfg_new[`PFB_B_DIST];
                cfg_pin_q   <= cfg_new[`PFB_B_PIN];
                cfg_depth_q <= new_depth;
            end
            if (do_wr && awaddr_q == `PFB_A_NOTIFY) begin
                notify_q <= CW'(merge({{(32-CW){1'b0}}, notify_q},
                                      wdata_q, wstrb_q));
            end
            if (do_wr && awaddr_q == `PFB_A_IMASK) begin
                imask_q <= 4'(merge({28'h0, imask_q}, wdata_q, wstrb_q));
            end
        end
    end

    // interrupt status: write one clears, a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_q <= '0;
            irq     <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~((do_wr && awaddr_q == `PFB_A_ISTAT)
                        ? 4'(merge(32'h0, wdata_q, wstrb_q)) : 4'h0))
                       | {done_ev, cfg_wr && cfg_bad, drop,
                          flag_d && !fill_flag_pin};
            irq     <= |(istat_q & imask_q);
        end
    end

    // ---------------- axi4-lite read side ----------------
    always_comb begin
        rd_ok   = 1'b1;
        rd_word = '0;
        unique case (araddr)
            `PFB_A_CFG:    rd_word = cfg_rd;
            `PFB_A_NOTIFY: rd_word = {{(32-CW){1'b0}}, notify_q};
            `PFB_A_STATUS: rd_word = stat_word;
            `PFB_A_ISTAT:  rd_word = {28'h0, istat_q};
            `PFB_A_IMASK:  rd_word = {28'h0, imask_q};
            default:       rd_ok   = 1'b0;
        endcase
    end

    // read address taken, data registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `PFB_RESP_OK;
        end else begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_ok ? `PFB_RESP_OK : `PFB_RESP_ERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
            arready <= !(arvalid && arready) && (!rvalid || rready);
        end
    end

    // ---------------- ring buffer ----------------
    assign active = cfg_en_q && cfg_depth_q != '0;
    assign flush  = !active || cfg_apply;
    assign full   = cnt_q == cfg_depth_q;
    assign store  = fix_valid && active && !cfg_apply;
    assign drop   = store && full && !pop;

    pfb_ring #(
        .WIDTH (96),
        .DEPTH (MAX_DEPTH),
        .AW    (CW)
    ) u_ring (
        .aclk  (aclk),
        .we    (store),
        .waddr (wr_ptr_q),
        .wdata ({fix_dist, fix_nav, fix_basic}),
        .raddr (rd_ptr_q),
        .rdata (mem_rd)
    );

    // pointers and fill level, wrapping at the configured depth
    always_ff @(posedge aclk) begin
        if (!aresetn || flush) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            cnt_q      <= '0;
            drop_cnt_q <= '0;
        end else begin
            if (store) begin
                wr_ptr_q <= (wr_ptr_q == cfg_depth_q - CW'(1))
                            ? '0 : wr_ptr_q + CW'(1);
            end
            if (drop || pop) begin
                rd_ptr_q <= (rd_ptr_q == cfg_depth_q - CW'(1))
                            ? '0 : rd_ptr_q + CW'(1);
            end
            cnt_q <= cnt_q + CW'(store && !drop) - CW'(pop);
            if (drop && drop_cnt_q != `PFB_DROP_MAX) begin
                drop_cnt_q <= drop_cnt_q + 16'h1;
            end
        end
    end

    // ---------------- retrieval sequencer ----------------
    assign ofree = !out_valid || out_ready;

    // next state and word to present
    always_comb begin
        st_d    = st_q;
        load    = 1'b0;
        ld_last = 1'b0;
        ld_stat = 1'b0;
        ld_data = '0;
        pop     = 1'b0;
        unique case (st_q)
            PFB_IDLE: begin
                if (req_valid) begin
                    st_d = req_status_first ? PFB_STAT : PFB_BASIC;
                end
            end
            PFB_STAT: begin
                if (ofree) begin
                    load    = 1'b1;
                    ld_stat = 1'b1;
                    ld_last = 1'b1;
                    ld_data = stat_word;
                    st_d    = PFB_BASIC;
                end
            end
            PFB_BASIC: begin
                if (rem_q == '0 || cnt_q == '0) begin
                    st_d = PFB_IDLE;
                end else if (ofree) begin
                    load    = 1'b1;
                    pop     = 1'b1;
                    ld_data = mem_rd[31:0];
                    ld_last = !cfg_nav_q && !cfg_dist_q;
                    st_d    = cfg_nav_q ? PFB_NAV
                            : (cfg_dist_q ? PFB_DIST : PFB_BASIC);
                end
            end
            PFB_NAV: begin
                if (ofree) begin
                    load    = 1'b1;
                    ld_data = hold_nav_q;
                    ld_last = !cfg_dist_q;
                    st_d    = cfg_dist_q ? PFB_DIST : PFB_BASIC;
                end
            end
            PFB_DIST: begin
                if (ofree) begin
                    load    = 1'b1;
                    ld_data = hold_dist_q;
                    ld_last = 1'b1;
                    st_d    = PFB_BASIC;
                end
            end
        endcase
        // erasing ends any retrieval at once
        if (flush) begin
            st_d = PFB_IDLE;
            load = 1'b0;
            pop  = 1'b0;
        end
    end
    assign done_ev = st_q != PFB_IDLE && st_d == PFB_IDLE;

    // entries left: snapshot on accept, only ever shrinks while busy
    always_comb begin
        rem_d = rem_q;
        if (st_q == PFB_IDLE) begin
            if (req_valid) begin
                rem_d = cnt_q;
            end
        end else if ((pop || drop) && rem_q != '0) begin
            rem_d = (rem_q > CW'(pop) + CW'(drop))
                    ? rem_q - CW'(pop) - CW'(drop) : '0;
        end
    end

    // sequencer registers and extended-block holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q        <= PFB_IDLE;
            rem_q       <= '0;
            hold_nav_q  <= '0;
            hold_dist_q <= '0;
        end else begin
            st_q  <= st_d;
            rem_q <= rem_d;
            if (pop) begin
                hold_nav_q  <= mem_rd[63:32];
                hold_dist_q <= mem_rd[95:64];
            end
        end
    end

    // output stream register, the only answer to a request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid  <= 1'b0;
            out_data   <= '0;
            out_status <= 1'b0;
            out_last   <= 1'b0;
        end else if (ofree) begin
            out_valid <= load;
            if (load) begin
                out_data   <= ld_data;
                out_status <= ld_stat;
                out_last   <= ld_last;
            end
        end
    end

    // fill-level flag pin
    assign flag_d = cfg_pin_q && active && notify_q != '0
                    && cnt_q >= notify_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_flag_pin <= 1'b0;
        end else begin
            fill_flag_pin <= flag_d;
        end
    end

    // ---------------- assertions ----------------
    property p_off_empty;
        @(posedge aclk) disable iff (!aresetn)
        !cfg_en_q |=> cnt_q == '0 && st_q == PFB_IDLE;
    endproperty
    a_off_empty: assert property (p_off_empty)
        else $error("buffer not empty while disabled");

    property p_flag_on;
        @(posedge aclk) disable iff (!aresetn)
        flag_d |=> fill_flag_pin;
    endproperty
    a_flag_on: assert property (p_flag_on)
        else $error("flag pin missed threshold");

    property p_flag_off;
        @(posedge aclk) disable iff (!aresetn)
        cnt_q < notify_q |=> !fill_flag_pin;
    endproperty
    a_flag_off: assert property (p_flag_off)
        else $error("flag pin high below threshold");

    property p_overwrite;
        @(posedge aclk) disable iff (!aresetn)
        drop && !flush && drop_cnt_q != `PFB_DROP_MAX |=>
            cnt_q == $past(cnt_q) && drop_cnt_q == $past(drop_cnt_q) + 16'h1;
    endproperty
    a_overwrite: assert property (p_overwrite)
        else $error("overrun did not replace oldest");

    property p_reject;
        @(posedge aclk) disable iff (!aresetn)
        cfg_wr && cfg_bad |=> $stable(cfg_rd);
    endproperty
    a_reject: assert property (p_reject)
        else $error("rejected config took effect");

    property p_limit;
        @(posedge aclk) disable iff (!aresetn)
        cfg_depth_q <= (cfg_nav_q ? (cfg_dist_q ? `PFB_MAX_11 : `PFB_MAX_10)
                        : (cfg_dist_q ? `PFB_MAX_01 : `PFB_MAX_00));
    endproperty
    a_limit: assert property (p_limit)
        else $error("depth above allowed maximum");

    property p_epoch;
        @(posedge aclk) disable iff (!aresetn)
        store && !full && !pop && !flush |=> cnt_q == $past(cnt_q) + CW'(1);
    endproperty
    a_epoch: assert property (p_epoch)
        else $error("fix not stored as one entry");

    property p_stat_first;
        @(posedge aclk) disable iff (!aresetn)
        st_q == PFB_IDLE && req_valid && req_status_first && !flush
            |=> st_q == PFB_STAT ##[1:300] (out_valid && out_status);
    endproperty
    a_stat_first: assert property (p_stat_first)
        else $error("status message not sent first");

    property p_busy_ignore;
        @(posedge aclk) disable iff (!aresetn)
        st_q != PFB_IDLE && req_valid |=> rem_q <= $past(rem_q);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("request accepted while busy");

    property p_no_ack;
        @(posedge aclk) disable iff (!aresetn)
        st_q == PFB_IDLE && !out_valid |=> !out_valid;
    endproperty
    a_no_ack: assert property (p_no_ack)
        else $error("output word without retrieval");
endmodule
`default_nettype wire

/* File: tb/pfb_host.sv */
// host model: drains the entry stream, stalling when asked
`timescale 1ns/1ns
`default_nettype none
module pfb_host (
    input  wire logic        aclk,
    input  wire logic        slow,
    input  wire logic        out_valid,
    output logic             out_ready,
    input  wire logic [31:0] out_data,
    input  wire logic        out_status,
    input  wire logic        out_last
);
    logic [31:0] got[$];        // words taken, in arrival order
    logic [1:0]  kind[$];       // {status, last} of each word taken
    logic        tog_q = 1'b0;  // stall pattern when slow
    // take one word at each handshake edge, never skip one
    always @(posedge aclk) begin
        tog_q <= ~tog_q;
        if (out_valid && out_ready) begin
            got.push_back(out_data);
            kind.push_back({out_status, out_last});
        end
    end
    // slow host takes a word only every other cycle, sends nothing itself
    assign out_ready = slow ? tog_q : 1'b1;
endmodule
`default_nettype wire

/* File: tb/test_pfb_top.sv */
// testbench for the position fix batch buffer
`timescale 1ns/1ns
`default_nettype none
`include "pfb_cfg.svh"
module test_pfb_top;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0;
    logic        bready = 0, arvalid = 0, rready = 0, fix_valid = 0;
    logic        req_valid = 0, req_status_first = 0, slow = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [3:0]  wstrb = 4'hf;
    logic [31:0] wdata = 0, fix_basic = 0, fix_nav = 0, fix_dist = 0;
    logic        awready, wready, bvalid, arready, rvalid, out_valid;
    logic        out_ready, out_status, out_last, fill_flag_pin, irq;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, out_data, v, prev;
    int          fails = 0, n_checks = 0, cyc = 0;
    int          lim[4] = '{600, 443, 309, 261};  // index {nav, dist}

    pfb_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fix_valid,
        .fix_basic, .fix_nav, .fix_dist, .req_valid, .req_status_first,
        .out_valid, .out_ready, .out_data, .out_status, .out_last,
        .fill_flag_pin, .irq);
    pfb_host u_host (.aclk, .slow, .out_valid, .out_ready, .out_data,
        .out_status, .out_last);

    always #25 aclk = ~aclk;
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // axi4-lite write: address and data together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask

    // axi4-lite read
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask

    // one fix per navigation epoch
    task automatic fix(input logic [31:0] b);
        fix_valid <= 1;
        fix_basic <= b;
        fix_nav <= ~b;
        fix_dist <= b + 32'h1;
        @(posedge aclk);
        fix_valid <= 0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic t_idle();
        fix(32'h11);
        rd(`PFB_A_STATUS);
        chk(v, 32'h0);
        rd(8'h20);
        chk({30'h0, r}, 32'h2);
    endtask

    // each depth limit: one above refused, the limit itself taken
    task automatic t_limits();
        prev = 32'h0;
        for (int i = 0; i < 4; i++) begin
            wr(`PFB_A_CFG, (32'(lim[i] + 1) << 16) | {29'h0, i[0], i[1], 1'b1});
            chk({30'h0, r}, 32'h2);
            rd(`PFB_A_CFG);
            chk(v, prev);
            prev = (32'(lim[i]) << 16) | {29'h0, i[0], i[1], 1'b1};
            wr(`PFB_A_CFG, prev);
            chk({30'h0, r}, 32'h0);
        end
    endtask

    // depth 3, notify at 2, overrun drops the oldest
    task automatic t_fill();
        wr(`PFB_A_IMASK, 32'h2);
        wr(`PFB_A_NOTIFY, 32'h2);
        wr(`PFB_A_CFG, 32'h0003_0009);
        fix(32'h1);
        chk({31'h0, fill_flag_pin}, 32'h0);
        fix(32'h2);
        chk({31'h0, fill_flag_pin}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        fix(32'h3);
        fix(32'h4);
        rd(`PFB_A_STATUS);
        chk(v, 32'h0001_0003);
        chk({31'h0, irq}, 32'h1);
        rd(`PFB_A_ISTAT);
        chk(v, 32'h7);
        wr(`PFB_A_ISTAT, 32'hf);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    // status first, then entries oldest first; second request ignored
    task automatic t_retrieve();
        slow <= 1;
        req_valid <= 1;
        req_status_first <= 1;
        @(posedge aclk);
        req_valid <= 0;
        repeat (3) @(posedge aclk);
        req_valid <= 1;
        @(posedge aclk);
        req_valid <= 0;
        for (int n = 0; n < 200 && u_host.got.size() < 4; n++)
            @(posedge aclk);
        repeat (30) @(posedge aclk);
        chk(u_host.got.size(), 32'h4);
        chk(u_host.got[0], 32'h0001_0003);
        chk({30'h0, u_host.kind[0]}, 32'h3);
        for (int i = 1; i < 4; i++) begin
            chk(u_host.got[i], 32'(i + 1));
            chk({30'h0, u_host.kind[i]}, 32'h1);
        end
        chk({31'h0, fill_flag_pin}, 32'h0);
        rd(`PFB_A_STATUS);
        chk(v, 32'h0001_0000);
    endtask

    // both detail blocks, no status first: three words per entry
    task automatic t_detail();
        wr(`PFB_A_CFG, 32'h0002_0007);
        fix(32'h7);
        req_valid <= 1;
        req_status_first <= 0;
        @(posedge aclk);
        req_valid <= 0;
        for (int n = 0; n < 200 && u_host.got.size() < 7; n++)
            @(posedge aclk);
        repeat (30) @(posedge aclk);
        chk(u_host.got.size(), 32'h7);
        chk(u_host.got[4], 32'h7);
        chk(u_host.got[5], 32'hffff_fff8);
        chk(u_host.got[6], 32'h8);
        chk({30'h0, u_host.kind[4]}, 32'h0);
        chk({30'h0, u_host.kind[5]}, 32'h0);
        chk({30'h0, u_host.kind[6]}, 32'h1);
    endtask

    // turning batching off loses the stored fixes
    task automatic t_erase();
        fix(32'h5);
        wr(`PFB_A_CFG, 32'h0);
        rd(`PFB_A_STATUS);
        chk(v, 32'h0);
        fix(32'h6);
        rd(`PFB_A_STATUS);
        chk(v, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        t_idle();
        t_limits();
        t_fill();
        t_retrieve();
        t_detail();
        t_erase();
        finish_test();
    end
endmodule
`default_nettype wire
